// ===== core/pmu_ctrl.sv
// Register bank and relay sequencing for the precision measurement unit.
// Assumes the tester controller drives the long register bus asynchronously;
// every bus pin is brought into the clock domain through two flip-flops.
//
// Functional notes
// - Comparator-test bits drive the bus only when read with its select and no mux select.
// - Controller holds bus bit 14 line high while writing the comparator-test register.
// - Bit 14 line falling during comparator-test write strobes pass into the fail flag.
// - Reading the comparator-test register also issues the compare strobe.
// - Comparator-test read returns the fail flag in bit 14.
// - Level register is 14 bits; bits 0-7 latch on level select writes.
// - Level bit 8 is a read-only spare that reads zero.
// - Level bit 9 is a stored spare with no function.
// - Level bit 10, range enable, is write-only and reads zero.
// - Level bits 11 and 12 hold the current-range code.
// - Level bit 13 reads as complement of supply bit 13, ignores writes.
// - Level register drives the bus on read with level select, no supply select.
// - Supply force-mode high: relays follow the level register range code.
// - Code 3 selects K3-K5, 2 selects K2, 1 selects K1, 0 none.
// - Supply force-mode low: relays follow the supply register range code.
// - Any relay selection change starts a pulse of typically 4.2 ms.
// - During the pulse, busy is asserted and relay drivers are enabled.
// - Pass is comparator output XOR go/no-go sense; strobe captures it.
// - Comparator-test bits 11 and 12 read the level range, never written.
// - Supply register latches on supply select with write and cycle low.
module pmu_ctrl #(
  parameter int unsigned RELAY_PULSE_CYCLES = pmu_pkg::RELAY_PULSE_CYCLES
) (
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  // Long register bus, lines active low
  input  wire logic [pmu_pkg::BUS_W-1:0]   long_bus_in_n,
  output logic      [pmu_pkg::BUS_W-1:0]   long_bus_out_n,
  output logic      [pmu_pkg::BUS_W-1:0]   long_bus_oe,
  input  wire logic                        cmp_test_select,
  input  wire logic                        level_select,
  input  wire logic                        supply_select,
  input  wire logic                        read_n,
  input  wire logic                        write_n,
  input  wire logic                        periph_cycle_n,
  // Analog board
  input  wire logic                        comparator_in,
  output logic      [4:0]                  voltage_bits,
  output logic                             high_voltage_select,
  output logic                             positive_clamp,
  output logic                             negative_clamp,
  output logic                             range_enable_bit,
  output logic                             level_force_mode,
  output logic                             supply_force_mode,
  output logic      [9:0]                  supply_level_data,
  output logic                             supply_polarity,
  output logic      [9:0]                  cmp_level_data,
  output logic                             cmp_polarity,
  output logic                             compare_strobe,
  output logic                             compare_fail_flag,
  output logic      [pmu_pkg::RELAY_W-1:0] relay_select,
  output logic                             relay_drive_en,
  output logic                             tester_busy_n
);

  localparam int unsigned CTL_W = 7;

  function automatic logic rose(input logic prev, input logic now);
    rose = now & ~prev;
  endfunction

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [pmu_pkg::BUS_W-1:0] bus_meta;
  logic [pmu_pkg::BUS_W-1:0] bus_sync_n;
  logic [CTL_W-1:0]          ctl_meta;
  logic [CTL_W-1:0]          ctl_sync;
  logic [CTL_W-1:0]          ctl_raw;

  assign ctl_raw = {comparator_in, periph_cycle_n, write_n, read_n,
                    supply_select, level_select, cmp_test_select};

  // Idle bus lines float high, so the reset value is all ones
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bus_meta   <= '1;
      bus_sync_n <= '1;
      // Strobes idle high and selects low, so release starts no access
      ctl_meta   <= 7'h38;
      ctl_sync   <= 7'h38;
    end else begin
      bus_meta   <= long_bus_in_n;
      bus_sync_n <= bus_meta;
      ctl_meta   <= ctl_raw;
      ctl_sync   <= ctl_meta;
    end
  end

  logic s_cmp_sel;
  logic s_lvl_sel;
  logic s_sup_sel;
  logic s_rd;
  logic s_wr;
  logic s_comp;
  logic [pmu_pkg::BUS_W-1:0] bus_data;

  assign s_cmp_sel = ctl_sync[0];
  assign s_lvl_sel = ctl_sync[1];
  assign s_sup_sel = ctl_sync[2];
  assign s_rd      = ~ctl_sync[3];
  assign s_wr      = ~ctl_sync[4] & ~ctl_sync[5];
  assign s_comp    = ctl_sync[6];
  assign bus_data  = ~bus_sync_n;

  // ---------------------------------------------------------------
  // Register latches
  // ---------------------------------------------------------------
  logic [pmu_pkg::REG_W-1:0] level_control;
  logic [pmu_pkg::REG_W-1:0] next_level_control;
  logic [pmu_pkg::REG_W-1:0] supply_reg;
  logic [pmu_pkg::REG_W-1:0] next_supply_reg;
  logic [pmu_pkg::REG_W-1:0] cmp_reg;
  logic [pmu_pkg::REG_W-1:0] next_cmp_reg;
  logic                      lvl_wr;
  logic                      sup_wr;
  logic                      cmp_wr;

  assign lvl_wr = s_wr & s_lvl_sel;
  assign sup_wr = s_wr & s_sup_sel;
  // Bit 14 line high gates the data; its falling edge is the strobe instead
  assign cmp_wr = s_wr & s_cmp_sel & bus_sync_n[pmu_pkg::STROBE_BIT];

  always_comb begin
    next_level_control = level_control;
    next_supply_reg    = supply_reg;
    next_cmp_reg       = cmp_reg;
    if (lvl_wr) begin
      next_level_control[pmu_pkg::NEG_CLP_BIT:0] = bus_data[pmu_pkg::NEG_CLP_BIT:0];
      next_level_control[pmu_pkg::SPARE_RW_BIT]  = bus_data[pmu_pkg::SPARE_RW_BIT];
      next_level_control[pmu_pkg::RANGE_EN_BIT]  = bus_data[pmu_pkg::RANGE_EN_BIT];
      next_level_control[pmu_pkg::RANGE_HI_BIT:pmu_pkg::RANGE_LO_BIT] =
        bus_data[pmu_pkg::RANGE_HI_BIT:pmu_pkg::RANGE_LO_BIT];
    end
    // Bits 8 and 13 have no storage
    next_level_control[pmu_pkg::SPARE_RO_BIT] = 1'b0;
    next_level_control[pmu_pkg::MODE_BIT]     = 1'b0;
    if (sup_wr) begin
      next_supply_reg = bus_data[pmu_pkg::REG_W-1:0];
    end
    if (cmp_wr) begin
      next_cmp_reg[pmu_pkg::POL_BIT:0]     = bus_data[pmu_pkg::POL_BIT:0];
      next_cmp_reg[pmu_pkg::GO_NOGO_BIT]   = bus_data[pmu_pkg::GO_NOGO_BIT];
    end
    // Range bits are shared with the level register
    next_cmp_reg[pmu_pkg::RANGE_HI_BIT:pmu_pkg::RANGE_LO_BIT] = 2'h0;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      level_control <= pmu_pkg::LEVEL_RST;
      supply_reg    <= pmu_pkg::SUPPLY_RST;
      cmp_reg       <= pmu_pkg::CMP_RST;
    end else begin
      level_control <= next_level_control;
      supply_reg    <= next_supply_reg;
      cmp_reg       <= next_cmp_reg;
    end
  end

  // Level force mode is the complement of the supply mode bit, one cycle later
  logic next_level_force_mode;

  always_comb begin
    next_level_force_mode = ~supply_reg[pmu_pkg::MODE_BIT];
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      level_force_mode <= 1'b1;
    end else begin
      level_force_mode <= next_level_force_mode;
    end
  end

  // ---------------------------------------------------------------
  // Compare strobe and fail flag
  // ---------------------------------------------------------------
  logic pass;
  logic cmp_rd;
  logic b14_low;
  logic prev_cmp_rd;
  logic prev_b14_low;
  logic strobe_now;
  logic next_fail;

  assign pass    = s_comp ^ cmp_reg[pmu_pkg::GO_NOGO_BIT];
  assign cmp_rd  = s_rd & s_cmp_sel;
  assign b14_low = s_wr & s_cmp_sel & ~bus_sync_n[pmu_pkg::STROBE_BIT];
  // Strobe once at the start of each read so the read data stays stable
  assign strobe_now = rose(prev_b14_low, b14_low) | rose(prev_cmp_rd, cmp_rd);

  always_comb begin
    next_fail = compare_fail_flag;
    if (strobe_now) begin
      next_fail = ~pass;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prev_cmp_rd       <= 1'b0;
      prev_b14_low      <= 1'b0;
      compare_strobe    <= 1'b0;
      compare_fail_flag <= 1'b0;
    end else begin
      prev_cmp_rd       <= cmp_rd;
      prev_b14_low      <= b14_low;
      compare_strobe    <= strobe_now;
      compare_fail_flag <= next_fail;
    end
  end

  // ---------------------------------------------------------------
  // Read multiplexer
  // ---------------------------------------------------------------
  pmu_pkg::pmu_rd_src_e      rd_src;
  logic [pmu_pkg::BUS_W-1:0] rd_data;
  logic [pmu_pkg::BUS_W-1:0] rd_oe;
  logic [pmu_pkg::BUS_W-1:0] next_bus_out_n;
  logic [pmu_pkg::BUS_W-1:0] next_bus_oe;

  always_comb begin
    rd_src = pmu_pkg::PMU_RD_NONE;
    if (s_rd) begin
      if (s_sup_sel && !s_lvl_sel) begin
        rd_src = pmu_pkg::PMU_RD_SUPPLY;
      end else if (s_lvl_sel && !s_sup_sel) begin
        rd_src = pmu_pkg::PMU_RD_LEVEL;
      end else if (!s_lvl_sel && !s_sup_sel && s_cmp_sel) begin
        rd_src = pmu_pkg::PMU_RD_CMP;
      end
    end
  end

  always_comb begin
    rd_data = '0;
    rd_oe   = '0;
    case (rd_src)
      pmu_pkg::PMU_RD_SUPPLY: begin
        rd_data = {1'b0, supply_reg};
        rd_oe   = 15'h3fff;
      end
      pmu_pkg::PMU_RD_LEVEL: begin
        rd_data = {1'b0, level_force_mode, level_control[12:11], 1'b0,
                   level_control[9], 1'b0, level_control[7:0]};
        rd_oe   = 15'h3fff;
      end
      pmu_pkg::PMU_RD_CMP: begin
        rd_data = {compare_fail_flag, cmp_reg[13], level_control[12:11],
                   cmp_reg[10:0]};
        rd_oe   = 15'h7fff;
      end
      pmu_pkg::PMU_RD_NONE: begin
        rd_data = '0;
        rd_oe   = '0;
      end
      default: begin
        rd_data = '0;
        rd_oe   = '0;
      end
    endcase
    next_bus_out_n = ~rd_data;
    next_bus_oe    = rd_oe;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      long_bus_out_n <= '1;
      long_bus_oe    <= '0;
    end else begin
      long_bus_out_n <= next_bus_out_n;
      long_bus_oe    <= next_bus_oe;
    end
  end

  // ---------------------------------------------------------------
  // Current range relays
  // ---------------------------------------------------------------
  logic [1:0]                range_code;
  logic [pmu_pkg::RELAY_W-1:0] relay_ff;
  logic [pmu_pkg::RELAY_W-1:0] next_relay_ff;
  logic                      relay_change;
  logic                      pulse_active;

  always_comb begin
    if (supply_reg[pmu_pkg::MODE_BIT]) begin
      range_code = level_control[pmu_pkg::RANGE_HI_BIT:pmu_pkg::RANGE_LO_BIT];
    end else begin
      range_code = supply_reg[pmu_pkg::RANGE_HI_BIT:pmu_pkg::RANGE_LO_BIT];
    end
    next_relay_ff = '0;
    case (range_code)
      2'h3:    next_relay_ff[pmu_pkg::RLY_K345] = 1'b1;
      2'h2:    next_relay_ff[pmu_pkg::RLY_K2]   = 1'b1;
      2'h1:    next_relay_ff[pmu_pkg::RLY_K1]   = 1'b1;
      default: next_relay_ff = '0;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      relay_ff <= pmu_pkg::RELAY_RST;
    end else begin
      relay_ff <= next_relay_ff;
    end
  end

  assign relay_change = (next_relay_ff != relay_ff);

  pmu_relay_timer #(
    .PULSE_CYCLES (RELAY_PULSE_CYCLES)
  ) u_timer (
    .clock   (clock),
    .rst_n   (rst_n),
    .trigger (relay_change),
    .active  (pulse_active)
  );

  // Drivers see the new selection together with the enable
  logic next_busy_n;

  always_comb begin
    next_busy_n = ~pulse_active;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tester_busy_n  <= 1'b1;
      relay_drive_en <= 1'b0;
      relay_select   <= pmu_pkg::RELAY_RST;
    end else begin
      tester_busy_n  <= next_busy_n;
      relay_drive_en <= pulse_active;
      relay_select   <= relay_ff;
    end
  end

  // ---------------------------------------------------------------
  // Analog control fields, straight from the latches
  // ---------------------------------------------------------------
  assign voltage_bits        = level_control[pmu_pkg::VOLT_MSB:pmu_pkg::VOLT_LSB];
  assign high_voltage_select = level_control[pmu_pkg::HV_SEL_BIT];
  assign positive_clamp      = level_control[pmu_pkg::POS_CLP_BIT];
  assign negative_clamp      = level_control[pmu_pkg::NEG_CLP_BIT];
  assign range_enable_bit    = level_control[pmu_pkg::RANGE_EN_BIT];
  assign supply_force_mode   = supply_reg[pmu_pkg::MODE_BIT];
  assign supply_level_data   = supply_reg[pmu_pkg::DATA_MSB:pmu_pkg::DATA_LSB];
  assign supply_polarity     = supply_reg[pmu_pkg::POL_BIT];
  assign cmp_level_data      = cmp_reg[pmu_pkg::DATA_MSB:pmu_pkg::DATA_LSB];
  assign cmp_polarity        = cmp_reg[pmu_pkg::POL_BIT];

endmodule

// ===== core/pmu_pkg.sv
// Constants shared by the measurement-unit control block: bus field layout,
// register field positions, reset values and relay pulse timing.
// Assumes a 50 MHz system clock and a 15-line inverted long register bus.
package pmu_pkg;

  // Bus and register widths
  localparam int unsigned BUS_W        = 15;
  localparam int unsigned REG_W        = 14;
  localparam int unsigned RELAY_W      = 3;
  localparam int unsigned TIMER_W      = 18;

  // Shared bit positions
  localparam int unsigned RANGE_LO_BIT = 11;
  localparam int unsigned RANGE_HI_BIT = 12;
  localparam int unsigned MODE_BIT     = 13;
  localparam int unsigned STROBE_BIT   = 14;

  // Level register fields
  localparam int unsigned VOLT_LSB     = 0;
  localparam int unsigned VOLT_MSB     = 4;
  localparam int unsigned HV_SEL_BIT   = 5;
  localparam int unsigned POS_CLP_BIT  = 6;
  localparam int unsigned NEG_CLP_BIT  = 7;
  localparam int unsigned SPARE_RO_BIT = 8;
  localparam int unsigned SPARE_RW_BIT = 9;
  localparam int unsigned RANGE_EN_BIT = 10;

  // Supply and comparator-test register fields
  localparam int unsigned DATA_LSB     = 0;
  localparam int unsigned DATA_MSB     = 9;
  localparam int unsigned POL_BIT      = 10;
  localparam int unsigned GO_NOGO_BIT  = 13;

  // Relay selection slots
  localparam int unsigned RLY_K1       = 0;
  localparam int unsigned RLY_K2       = 1;
  localparam int unsigned RLY_K345     = 2;

  // Reset values
  localparam logic [13:0] LEVEL_RST    = 14'h0000;
  localparam logic [13:0] SUPPLY_RST   = 14'h0000;
  localparam logic [13:0] CMP_RST      = 14'h0000;
  localparam logic [2:0]  RELAY_RST    = 3'h0;

  // Relay change pulse, typical width
  localparam int unsigned CLK_PERIOD_NS     = 20;
  localparam int unsigned RELAY_PULSE_NS    = 4200000;
  localparam int unsigned RELAY_PULSE_CYCLES = RELAY_PULSE_NS / CLK_PERIOD_NS;

  // Read source on the bus
  typedef enum logic [1:0] {
    PMU_RD_NONE   = 2'b00,
    PMU_RD_SUPPLY = 2'b01,
    PMU_RD_LEVEL  = 2'b10,
    PMU_RD_CMP    = 2'b11
  } pmu_rd_src_e;

endpackage

// ===== core/pmu_relay_timer.sv
// Retriggerable down-counter that stands in for the relay one-shot.
// Assumes trigger is a one-cycle pulse from logic on the same clock.
module pmu_relay_timer #(
  parameter int unsigned PULSE_CYCLES = pmu_pkg::RELAY_PULSE_CYCLES
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic trigger,
  output logic      active
);

  localparam logic [pmu_pkg::TIMER_W-1:0] LOAD = pmu_pkg::TIMER_W'(PULSE_CYCLES);

  logic [pmu_pkg::TIMER_W-1:0] count;
  logic [pmu_pkg::TIMER_W-1:0] next_count;

  always_comb begin
    next_count = count;
    if (trigger) begin
      // A further change restarts the full width
      next_count = LOAD;
    end else if (count != '0) begin
      next_count = count - pmu_pkg::TIMER_W'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign active = (count != '0);

endmodule

// ===== dv/pmu_ctrl_monitor.sv
// Port-level concurrent checks for the measurement-unit control block.
// Assumes bus pins are held steady for several clocks around each access.
module pmu_ctrl_monitor #(
  parameter int unsigned RELAY_PULSE_CYCLES = 20
) (
  input wire logic                      clock,
  input wire logic                      rst_n,
  input wire logic [pmu_pkg::BUS_W-1:0] long_bus_out_n,
  input wire logic [pmu_pkg::BUS_W-1:0] long_bus_oe,
  input wire logic                      cmp_test_select,
  input wire logic                      level_select,
  input wire logic                      supply_select,
  input wire logic                      read_n,
  input wire logic                      write_n,
  input wire logic                      level_force_mode,
  input wire logic                      supply_force_mode,
  input wire logic                      compare_strobe,
  input wire logic                      compare_fail_flag,
  input wire logic [2:0]                relay_select,
  input wire logic                      relay_drive_en,
  input wire logic                      tester_busy_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [17:0] since_chg;
  logic [17:0] next_since_chg;
  logic [2:0]  prev_relay;

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Age of the current relay selection, to bound the busy pulse
  always_comb next_since_chg = (relay_select != prev_relay) ? 18'h0 : since_chg + 18'h1;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      since_chg  <= 18'h0;
      prev_relay <= 3'h0;
    end else begin
      since_chg  <= next_since_chg;
      prev_relay <= relay_select;
    end
  end

  cmp_drive_cond_a: assert property ($rose(long_bus_oe[14]) |-> $past(cmp_test_select, 3) && !$past(read_n, 3)
    && !$past(level_select, 3) && !$past(supply_select, 3)) else $error("bit 14 driven outside a test read");
  read_drive_cond_a: assert property ($rose(long_bus_oe[0]) |-> !$past(read_n, 3)
    && !($past(level_select, 3) && $past(supply_select, 3))) else $error("bus driven outside a read");
  strobe_cause_a: assert property (compare_strobe |-> $past(cmp_test_select, 3)
    && (!$past(read_n, 3) || !$past(write_n, 3))) else $error("strobe without test access");
  strobe_pulse_a: assert property (compare_strobe |=> !compare_strobe) else $error("strobe longer than one cycle");
  fail_on_strobe_a: assert property ($changed(compare_fail_flag) |-> compare_strobe) else $error("fail moved alone");
  fail_readback_a: assert property (long_bus_oe[14] && !compare_strobe && !$past(compare_strobe)
    |-> long_bus_out_n[14] == !compare_fail_flag) else $error("bit 14 read differs from fail");
  level_spares_a: assert property (long_bus_oe[0] && !long_bus_oe[14] && $past(level_select, 3)
    && !$past(supply_select, 3) |-> long_bus_out_n[8] && long_bus_out_n[10]
    && long_bus_out_n[13] == supply_force_mode) else $error("level read spare bits wrong");
  mode_invert_a: assert property (level_force_mode == !$past(supply_force_mode)) else $error("mode not inverse");
  decode_onehot_a: assert property ($onehot0(relay_select)) else $error("relay select not one-hot");
  change_busy_a: assert property ($changed(relay_select) |=> !tester_busy_n) else $error("no busy on change");
  busy_drive_a: assert property (tester_busy_n == !relay_drive_en) else $error("drive enable and busy differ");
  pulse_width_a: assert property ($rose(tester_busy_n) |-> since_chg >= RELAY_PULSE_CYCLES - 1
    && since_chg <= RELAY_PULSE_CYCLES + 1) else $error("busy pulse width wrong");
endmodule

bind pmu_ctrl pmu_ctrl_monitor #(.RELAY_PULSE_CYCLES(RELAY_PULSE_CYCLES)) u_mon (
  .clock(clock), .rst_n(rst_n), .long_bus_out_n(long_bus_out_n), .long_bus_oe(long_bus_oe),
  .cmp_test_select(cmp_test_select), .level_select(level_select), .supply_select(supply_select),
  .read_n(read_n), .write_n(write_n), .level_force_mode(level_force_mode),
  .supply_force_mode(supply_force_mode), .compare_strobe(compare_strobe),
  .compare_fail_flag(compare_fail_flag), .relay_select(relay_select),
  .relay_drive_en(relay_drive_en), .tester_busy_n(tester_busy_n));

// ===== dv/pmu_ctl_model.sv
// Behavioural tester controller on the inverted long register bus.
// Assumes the bench wire-ANDs its lines with the block's drive into bus_n.
module pmu_ctl_model (
  input  wire logic        clock,
  input  wire logic [14:0] bus_n,
  output logic      [14:0] drv_n,
  output logic      [2:0]  sel,
  output logic             read_n,
  output logic             write_n,
  output logic             periph_cycle_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    drv_n = '1;
    sel = 3'h0;
    read_n = 1'b1;
    write_n = 1'b1;
    periph_cycle_n = 1'b1;
  end

  // Selects are {test, level, supply}; strobes drop with data and selects, and rise a clock before they are released
  task automatic access(input logic [2:0] s, input logic wr, input logic [14:0] d, input int hold,
                        output logic [14:0] q);
    @(posedge clock);
    sel <= s;
    if (wr) begin
      drv_n <= ~d;
      write_n <= 1'b0;
      periph_cycle_n <= 1'b0;
    end else begin
      read_n <= 1'b0;
    end
    repeat (hold) @(posedge clock);
    q = ~bus_n;
    read_n <= 1'b1;
    write_n <= 1'b1;
    periph_cycle_n <= 1'b1;
    @(posedge clock);
    sel <= 3'h0;
    drv_n <= '1;
    repeat (3) @(posedge clock);
  endtask
endmodule

// ===== dv/tb.sv
// Self-checking bench for the measurement-unit control block.
// Assumes the block is built with a short relay pulse for simulation.
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PULSE = 20;
  logic clock = 1'b0, rst_n = 1'b0, comparator_in = 1'b0;
  logic [14:0] bus_n, drv_n, out_n, oe, q;
  logic [2:0] sel, relay_select;
  logic read_n, write_n, periph_cycle_n, high_voltage_select, positive_clamp, negative_clamp;
  logic range_enable_bit, level_force_mode, supply_force_mode, supply_polarity, cmp_polarity;
  logic compare_strobe, compare_fail_flag, relay_drive_en, tester_busy_n;
  logic [4:0] voltage_bits;
  logic [9:0] supply_level_data, cmp_level_data;
  int checks = 0, n_mismatch = 0, cyc = 0, low_cnt = 0, last_low = 0;
  int lvl = 0, sup = 0, cmp = 0, fail = 0, code;
  logic [15:0] seed = 16'h005c;

  always #10 clock = ~clock;
  assign bus_n = drv_n & (~oe | out_n);

  pmu_ctl_model u_ctl (.clock(clock), .bus_n(bus_n), .drv_n(drv_n), .sel(sel), .read_n(read_n),
    .write_n(write_n), .periph_cycle_n(periph_cycle_n));
  pmu_ctrl #(.RELAY_PULSE_CYCLES(PULSE)) dut (.clock(clock), .rst_n(rst_n), .long_bus_in_n(bus_n),
    .long_bus_out_n(out_n), .long_bus_oe(oe), .cmp_test_select(sel[2]), .level_select(sel[1]),
    .supply_select(sel[0]), .read_n(read_n), .write_n(write_n), .periph_cycle_n(periph_cycle_n),
    .comparator_in(comparator_in), .voltage_bits(voltage_bits), .high_voltage_select(high_voltage_select),
    .positive_clamp(positive_clamp), .negative_clamp(negative_clamp), .range_enable_bit(range_enable_bit),
    .level_force_mode(level_force_mode), .supply_force_mode(supply_force_mode),
    .supply_level_data(supply_level_data), .supply_polarity(supply_polarity), .cmp_level_data(cmp_level_data),
    .cmp_polarity(cmp_polarity), .compare_strobe(compare_strobe), .compare_fail_flag(compare_fail_flag),
    .relay_select(relay_select), .relay_drive_en(relay_drive_en), .tester_busy_n(tester_busy_n));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Busy pulse length and run-time ceiling
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (!tester_busy_n) low_cnt <= low_cnt + 1;
    else if (low_cnt != 0) begin
      last_low <= low_cnt;
      low_cnt <= 0;
    end
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // Index 0 supply, 1 level, 2 comparator test
  task automatic put(input int r, input logic [14:0] d);
    u_ctl.access(3'b001 << r, 1'b1, d, 6, q);
    if (r == 0) sup = d & 'h3fff;
    else if (r == 1) lvl = d & 'h1eff;
    else if (!d[14]) cmp = d & 'h27ff;
    else fail = !(comparator_in ^ cmp[13]);
  endtask

  task automatic get(input int r, input int hold);
    int e;
    u_ctl.access(3'b001 << r, 1'b0, 15'h0, hold, q);
    if (r == 2) fail = !(comparator_in ^ cmp[13]);
    e = (r == 0) ? sup : (r == 1) ? ((lvl & 'h1aff) | (!sup[13] << 13))
      : ((cmp & 'h27ff) | (lvl & 'h1800) | (fail << 14));
    `CHK("read data", e[14:0], q)
  endtask

  task automatic chk_relay(input logic moved);
    logic [2:0] e;
    code = sup[13] ? lvl[12:11] : sup[12:11];
    e = (code == 3) ? 3'b100 : (code == 2) ? 3'b010 : (code == 1) ? 3'b001 : 3'b000;
    for (int i = 0; i < PULSE + 20 && !(tester_busy_n === 1'b1 && low_cnt == 0); i++) @(posedge clock);
    `CHK("relay_select", e, relay_select)
    if (moved) `CHK("busy length", PULSE, last_low)
  endtask

  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    `CHK("reset outputs", 7'b1000010, {tester_busy_n, compare_fail_flag, relay_select, level_force_mode, oe[0]})
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      put(1, seed[14:0]);
      `CHK("level outputs", {lvl[10], lvl[7:0]}, {range_enable_bit, negative_clamp, positive_clamp,
        high_voltage_select, voltage_bits})
      get(1, 6 + i);
    end
    $display("test level done");
    seed = lfsr(seed);
    put(0, 15'h2000 | seed[10:0]);
    `CHK("supply outputs", {sup[13], sup[10:0]}, {supply_force_mode, supply_polarity, supply_level_data})
    get(0, 6);
    get(1, 6);
    chk_relay(1'b0);
    for (int k = 0; k < 4; k++) begin
      put(1, (lvl & 'h07ff) | (((k * 3 + 2) % 4) << 11));
      chk_relay(1'b1);
    end
    put(0, 15'h1000);
    chk_relay(1'b1);
    $display("test relays done");
    for (int k = 0; k < 4; k++) begin
      comparator_in <= k[0];
      seed = lfsr(seed);
      put(2, (k[1] << 13) | seed[10:0]);
      `CHK("test outputs", cmp[10:0], {cmp_polarity, cmp_level_data})
      put(2, 15'h4000);
      `CHK("fail flag", fail[0], compare_fail_flag)
      comparator_in <= !k[0];
      get(2, 6);
    end
    $display("test compare done");
    u_ctl.access(3'b011, 1'b0, 15'h0, 6, q);
    `CHK("double select read", 15'h0, q)
    $display("test refusal done");
    tally_and_finish();
  end
endmodule
